// ===== verilog/flash_host_pkg.sv
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Serial flash opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_CHIP_LOCK = 8'h7E;
  localparam logic [7:0] OP_CHIP_UNLOCK = 8'h98;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_NO_OPERATION = 8'h00;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_READ_SECURITY = 8'h2B;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_ENHANCE_EXIT = 8'hFF;

  // ----------------------------------------------------------------
  // Command kinds written by software into the control register
  // ----------------------------------------------------------------
  localparam logic [3:0] K_WRITE_ENABLE_CMD = 4'h0;
  localparam logic [3:0] K_LOCK = 4'h1;
  localparam logic [3:0] K_UNLOCK = 4'h2;
  localparam logic [3:0] K_SUSPEND = 4'h3;
  localparam logic [3:0] K_RESUME = 4'h4;
  localparam logic [3:0] K_NOOP = 4'h5;
  localparam logic [3:0] K_RESET_ARM = 4'h6;
  localparam logic [3:0] K_RESET = 4'h7;
  localparam logic [3:0] K_RD_STATUS = 4'h8;
  localparam logic [3:0] K_RD_SECURITY = 4'h9;
  localparam logic [3:0] K_PROGRAM = 4'hA;
  localparam logic [3:0] K_ERASE = 4'hB;

  // ----------------------------------------------------------------
  // Register word indices and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_CONFIG = 3'h4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_RX_LSB = 8;
  localparam int STAT_PROG_SUS = 16;
  localparam int STAT_ERASE_SUS = 17;
  localparam int STAT_HOST_PROG_SUS = 18;
  localparam int STAT_HOST_ERASE_SUS = 19;
  localparam int CFG_QUAD = 0;
  localparam int CFG_ENHANCE = 1;
  localparam int SEC_PROG_SUS = 2;
  localparam int SEC_ERASE_SUS = 3;
  localparam int BANK_LSB = 19;
  localparam int BANK_W = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int SUSPEND_LAT_NS = 20000;
  localparam int SUSPEND_LAT_CYC = (SUSPEND_LAT_NS * CLK_MHZ + 999) / 1000;
  localparam int RESUME_GAP_NS = 1000000;
  localparam int RESUME_GAP_CYC = (RESUME_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int CS_HIGH_CYC = 4;
  localparam int SCLK_HALF_CYC = 4;

endpackage

// ===== verilog/serial_byte_shifter.sv
module serial_byte_shifter #(
  parameter int HALF = flash_host_pkg::SCLK_HALF_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic quad,
  input wire logic receive,
  input wire logic [7:0] txByte,
  input wire logic [3:0] dataIn,
  output logic done,
  output logic [7:0] rxByte,
  output logic sclk,
  output logic [3:0] dataOut,
  output logic [3:0] dataOe
);

  localparam int SPI_LEN = 16 * HALF;
  localparam int QPI_LEN = 4 * HALF;

  logic active;
  logic [7:0] shift;
  logic [2:0] stepsLeft;
  logic [7:0] divCnt;

  // ----------------------------------------------------------------
  // Lane selection
  // ----------------------------------------------------------------
  wire tick = active && (divCnt == 8'(HALF - 1));
  wire [7:0] shifted = quad ? {shift[3:0], 4'h0} : {shift[6:0], 1'b0};
  wire [7:0] nextRx = quad ? {rxByte[3:0], dataIn} :
                             {rxByte[6:0], dataIn[1]};
  wire [3:0] firstLanes = quad ? txByte[7:4] : {3'h0, txByte[7]};
  wire [3:0] nextLanes = quad ? shifted[7:4] : {3'h0, shifted[7]};
  wire [3:0] driveMask = receive ? 4'h0 : (quad ? 4'hF : 4'h1);

  // ----------------------------------------------------------------
  // Shifting, mode 0: data changes after the falling edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      active <= 1'b0;
      shift <= 8'h00;
      stepsLeft <= 3'h0;
      divCnt <= 8'h00;
      done <= 1'b0;
      rxByte <= 8'h00;
      sclk <= 1'b0;
      dataOut <= 4'h0;
      dataOe <= 4'h0;
    end else begin
      done <= 1'b0;
      if (start && !active) begin
        active <= 1'b1;
        shift <= txByte;
        stepsLeft <= quad ? 3'h1 : 3'h7;
        divCnt <= 8'h00;
        dataOut <= firstLanes;
        dataOe <= driveMask;
      end else if (active) begin
        divCnt <= tick ? 8'h00 : divCnt + 8'h01;
        if (tick && !sclk) begin
          sclk <= 1'b1;
        end else if (tick) begin
          sclk <= 1'b0;
          rxByte <= nextRx;
          shift <= shifted;
          dataOut <= nextLanes;
          stepsLeft <= stepsLeft - 3'h1;
          if (stepsLeft == 3'h0) begin
            active <= 1'b0;
            done <= 1'b1;
            dataOe <= 4'h0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  spi_byte_len_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(active) && !quad |-> ##SPI_LEN done)
    else $error("single-line byte did not take eight clocks");

  qpi_byte_len_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(active) && quad |-> ##QPI_LEN done)
    else $error("four-line byte did not take two clocks");

  spi_upper_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    active && !quad |-> dataOe[3:1] == 3'h0)
    else $error("upper data lines driven in single-line mode");

endmodule

// ===== verilog/flash_gang_suspend_host.sv
module flash_gang_suspend_host #(
  parameter int RESUME_GAP = flash_host_pkg::RESUME_GAP_CYC,
  parameter int SUSPEND_GAP = flash_host_pkg::SUSPEND_LAT_CYC,
  parameter int SCLK_HALF = flash_host_pkg::SCLK_HALF_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic flashCsN,
  output logic flashSclk,
  output logic [3:0] flashDataOut,
  output logic [3:0] flashDataOe,
  input wire logic [3:0] flashDataIn
);

  localparam int GW = $clog2(RESUME_GAP + 1);
  localparam int LW = $clog2(SUSPEND_GAP + 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_GAP, ST_SELECT, ST_SHIFT, ST_DESELECT, ST_LATENCY
  } state_e;
  typedef enum logic [1:0] {FR_EXIT, FR_WRITE_ENABLE_CMD, FR_MAIN} frame_e;

  state_e state;
  frame_e frame;
  logic [3:0] kind;
  logic [2:0] byteIdx;
  logic [2:0] csCnt;
  logic shiftStart;
  logic quadNow;
  logic [GW-1:0] gapCnt;
  logic [LW-1:0] latCnt;
  logic [3:0] dataInMeta;
  logic [3:0] dataInSync;
  logic [23:0] addrReg;
  logic [7:0] wdataReg;
  logic cfgQuad;
  logic cfgEnhance;
  logic refused;
  logic [7:0] rxReg;
  logic progSusFlag;
  logic eraseSusFlag;
  logic hostProgSus;
  logic hostEraseSus;
  logic lastOpErase;
  logic [flash_host_pkg::BANK_W-1:0] eraseBank;
  logic shiftDone;
  logic [7:0] shiftRx;
  logic [31:0] statusWord;
  logic [15:0] latSeen;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire busReq = avs_read || avs_write;
  wire busTake = busReq && !avs_waitrequest;
  wire wrTake = avs_write && busTake;
  wire wrCtrl = wrTake && (avs_address == flash_host_pkg::REG_CTRL);
  wire wrAddr = wrTake && (avs_address == flash_host_pkg::REG_ADDR);
  wire wrWdata = wrTake && (avs_address == flash_host_pkg::REG_WDATA);
  wire wrStatus = wrTake && (avs_address == flash_host_pkg::REG_STATUS);
  wire wrConfig = wrTake && (avs_address == flash_host_pkg::REG_CONFIG);
  wire [31:0] configWord = {30'h0, cfgEnhance, cfgQuad};
  wire [31:0] readMux =
    (avs_address == flash_host_pkg::REG_CTRL) ? {28'h0, kind} :
    (avs_address == flash_host_pkg::REG_ADDR) ? {8'h00, addrReg} :
    (avs_address == flash_host_pkg::REG_WDATA) ? {24'h0, wdataReg} :
    (avs_address == flash_host_pkg::REG_STATUS) ? statusWord :
    (avs_address == flash_host_pkg::REG_CONFIG) ? configWord : 32'h0;

  // ----------------------------------------------------------------
  // Command admission
  // ----------------------------------------------------------------
  wire [3:0] reqKind = avs_writedata[3:0];
  wire anySus = hostProgSus || hostEraseSus;
  wire reqBankHit = hostEraseSus && (addrReg[flash_host_pkg::BANK_LSB +:
                    flash_host_pkg::BANK_W] == eraseBank);
  wire reqBlocked = (reqKind > flash_host_pkg::K_ERASE) ||
    (anySus && (reqKind inside {flash_host_pkg::K_LOCK,
      flash_host_pkg::K_UNLOCK, flash_host_pkg::K_ERASE,
      flash_host_pkg::K_SUSPEND})) ||
    (reqKind == flash_host_pkg::K_PROGRAM && (hostProgSus || reqBankHit)) ||
    (reqKind == flash_host_pkg::K_RESET && hostEraseSus);
  wire startCmd = wrCtrl && (state == ST_IDLE) && !reqBlocked;
  wire refuseNow = wrCtrl && ((state != ST_IDLE) || reqBlocked);
  wire reqNeedsWren = reqKind inside {flash_host_pkg::K_LOCK,
    flash_host_pkg::K_UNLOCK, flash_host_pkg::K_PROGRAM,
    flash_host_pkg::K_ERASE};
  wire frame_e firstFrame =
    (reqKind == flash_host_pkg::K_RESUME && cfgEnhance) ? FR_EXIT :
    reqNeedsWren ? FR_WRITE_ENABLE_CMD : FR_MAIN;

  // ----------------------------------------------------------------
  // Frame contents
  // ----------------------------------------------------------------
  wire isReadKind = (kind == flash_host_pkg::K_RD_STATUS) ||
                    (kind == flash_host_pkg::K_RD_SECURITY);
  wire [2:0] mainLast = (kind == flash_host_pkg::K_PROGRAM) ? 3'h4 :
                        (kind == flash_host_pkg::K_ERASE) ? 3'h3 :
                        isReadKind ? 3'h1 : 3'h0;
  wire [7:0] opcode =
    (kind == flash_host_pkg::K_WRITE_ENABLE_CMD) ? flash_host_pkg::OP_WRITE_ENABLE :
    (kind == flash_host_pkg::K_LOCK) ? flash_host_pkg::OP_CHIP_LOCK :
    (kind == flash_host_pkg::K_UNLOCK) ? flash_host_pkg::OP_CHIP_UNLOCK :
    (kind == flash_host_pkg::K_SUSPEND) ? flash_host_pkg::OP_SUSPEND :
    (kind == flash_host_pkg::K_RESUME) ? flash_host_pkg::OP_RESUME :
    (kind == flash_host_pkg::K_RESET_ARM) ? flash_host_pkg::OP_RESET_ARM :
    (kind == flash_host_pkg::K_RESET) ? flash_host_pkg::OP_RESET :
    (kind == flash_host_pkg::K_RD_STATUS) ? flash_host_pkg::OP_READ_STATUS :
    (kind == flash_host_pkg::K_RD_SECURITY) ?
      flash_host_pkg::OP_READ_SECURITY :
    (kind == flash_host_pkg::K_PROGRAM) ? flash_host_pkg::OP_PAGE_PROGRAM :
    (kind == flash_host_pkg::K_ERASE) ? flash_host_pkg::OP_SECTOR_ERASE :
    flash_host_pkg::OP_NO_OPERATION;
  wire [7:0] frameByte =
    (frame == FR_EXIT) ? flash_host_pkg::OP_ENHANCE_EXIT :
    (frame == FR_WRITE_ENABLE_CMD) ? flash_host_pkg::OP_WRITE_ENABLE :
    (byteIdx == 3'h0) ? opcode :
    (byteIdx == 3'h1) ? addrReg[23:16] :
    (byteIdx == 3'h2) ? addrReg[15:8] :
    (byteIdx == 3'h3) ? addrReg[7:0] : wdataReg;
  wire shiftReceive = (frame == FR_MAIN) && isReadKind && (byteIdx == 3'h1);
  wire lastByte = (frame != FR_MAIN) || (byteIdx == mainLast);
  wire frameEnd = (state == ST_DESELECT) && (csCnt == 3'h0);
  wire cmdDone = frameEnd && (frame == FR_MAIN);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      frame <= FR_MAIN;
      kind <= flash_host_pkg::K_NOOP;
      byteIdx <= 3'h0;
      csCnt <= 3'h0;
      shiftStart <= 1'b0;
      quadNow <= 1'b0;
      flashCsN <= 1'b1;
    end else begin
      shiftStart <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (startCmd) begin
            kind <= reqKind;
            frame <= firstFrame;
            byteIdx <= 3'h0;
            quadNow <= cfgQuad;
            state <= (reqKind == flash_host_pkg::K_SUSPEND &&
                      gapCnt != '0) ? ST_GAP : ST_SELECT;
          end
        end
        ST_GAP: begin
          if (gapCnt == '0) state <= ST_SELECT;
        end
        ST_SELECT: begin
          flashCsN <= 1'b0;
          shiftStart <= 1'b1;
          state <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (shiftDone && lastByte) begin
            flashCsN <= 1'b1;
            csCnt <= 3'(flash_host_pkg::CS_HIGH_CYC - 1);
            state <= ST_DESELECT;
          end else if (shiftDone) begin
            byteIdx <= byteIdx + 3'h1;
            shiftStart <= 1'b1;
          end
        end
        ST_DESELECT: begin
          if (csCnt != 3'h0) begin
            csCnt <= csCnt - 3'h1;
          end else if (frame != FR_MAIN) begin
            frame <= FR_MAIN;
            state <= ST_SELECT;
          end else if (kind == flash_host_pkg::K_SUSPEND) begin
            state <= ST_LATENCY;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_LATENCY: begin
          if (latCnt == '0) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Suspend latency and resume-to-suspend spacing
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gapCnt <= '0;
      latCnt <= '0;
    end else begin
      if (cmdDone && kind == flash_host_pkg::K_RESUME)
        gapCnt <= GW'(RESUME_GAP);
      else if (gapCnt != '0)
        gapCnt <= gapCnt - GW'(1);
      if (cmdDone && kind == flash_host_pkg::K_SUSPEND)
        latCnt <= LW'(SUSPEND_GAP - 1);
      else if (latCnt != '0)
        latCnt <= latCnt - LW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Host view of suspension
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hostProgSus <= 1'b0;
      hostEraseSus <= 1'b0;
      lastOpErase <= 1'b0;
      eraseBank <= '0;
    end else if (cmdDone) begin
      case (kind)
        flash_host_pkg::K_SUSPEND: begin
          hostEraseSus <= lastOpErase;
          hostProgSus <= !lastOpErase;
        end
        flash_host_pkg::K_RESUME, flash_host_pkg::K_RESET: begin
          hostEraseSus <= 1'b0;
          hostProgSus <= 1'b0;
        end
        flash_host_pkg::K_ERASE: begin
          lastOpErase <= 1'b1;
          eraseBank <= addrReg[flash_host_pkg::BANK_LSB +:
                               flash_host_pkg::BANK_W];
        end
        flash_host_pkg::K_PROGRAM: begin
          if (!hostEraseSus) lastOpErase <= 1'b0;
        end
        default: lastOpErase <= lastOpErase;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read capture: status byte and suspend flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxReg <= 8'h00;
      progSusFlag <= 1'b0;
      eraseSusFlag <= 1'b0;
    end else if (shiftDone && shiftReceive) begin
      rxReg <= shiftRx;
      if (kind == flash_host_pkg::K_RD_SECURITY) begin
        progSusFlag <= shiftRx[flash_host_pkg::SEC_PROG_SUS];
        eraseSusFlag <= shiftRx[flash_host_pkg::SEC_ERASE_SUS];
      end
    end
  end

  always_comb begin
    statusWord = 32'h0;
    statusWord[flash_host_pkg::STAT_BUSY] = (state != ST_IDLE);
    statusWord[flash_host_pkg::STAT_REFUSED] = refused;
    statusWord[flash_host_pkg::STAT_RX_LSB +: 8] = rxReg;
    statusWord[flash_host_pkg::STAT_PROG_SUS] = progSusFlag;
    statusWord[flash_host_pkg::STAT_ERASE_SUS] = eraseSusFlag;
    statusWord[flash_host_pkg::STAT_HOST_PROG_SUS] = hostProgSus;
    statusWord[flash_host_pkg::STAT_HOST_ERASE_SUS] = hostEraseSus;
  end

  // ----------------------------------------------------------------
  // Software registers and bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      addrReg <= 24'h000000;
      wdataReg <= 8'h00;
      cfgQuad <= 1'b0;
      cfgEnhance <= 1'b0;
      refused <= 1'b0;
    end else begin
      avs_waitrequest <= !(busReq && avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= readMux;
      if (wrAddr) addrReg <= avs_writedata[23:0];
      if (wrWdata) wdataReg <= avs_writedata[7:0];
      if (wrConfig) begin
        cfgQuad <= avs_writedata[flash_host_pkg::CFG_QUAD];
        cfgEnhance <= avs_writedata[flash_host_pkg::CFG_ENHANCE];
      end else if (frameEnd && frame == FR_EXIT) begin
        cfgEnhance <= 1'b0;
      end
      if (refuseNow) refused <= 1'b1;
      else if (wrStatus && avs_writedata[flash_host_pkg::STAT_REFUSED])
        refused <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dataInMeta <= 4'h0;
      dataInSync <= 4'h0;
    end else begin
      dataInMeta <= flashDataIn;
      dataInSync <= dataInMeta;
    end
  end

  serial_byte_shifter #(.HALF(SCLK_HALF)) shifter (
    .clk(clk),
    .resetn(resetn),
    .start(shiftStart),
    .quad(quadNow),
    .receive(shiftReceive),
    .txByte(frameByte),
    .dataIn(dataInSync),
    .done(shiftDone),
    .rxByte(shiftRx),
    .sclk(flashSclk),
    .dataOut(flashDataOut),
    .dataOe(flashDataOe)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) latSeen <= 16'h0000;
    else latSeen <= (state == ST_LATENCY) ? latSeen + 16'h0001 : 16'h0000;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  cs_byte_edge_a: assert property (
    $rose(flashCsN) |-> $past(shiftDone) && !flashSclk)
    else $error("select raised off a byte boundary");

  write_enable_cmd_first_a: assert property (
    startCmd && reqNeedsWren |=> frame == FR_WRITE_ENABLE_CMD && state == ST_SELECT)
    else $error("write enable frame not sent first");

  write_enable_cmd_then_main_a: assert property (
    frameEnd && frame == FR_WRITE_ENABLE_CMD |=> frame == FR_MAIN && state == ST_SELECT)
    else $error("write enable not followed by its command");

  suspend_wait_a: assert property (
    state == ST_IDLE && $past(state) == ST_LATENCY |-> latSeen == SUSPEND_GAP)
    else $error("suspend latency not honoured");

  resume_gap_a: assert property (
    state == ST_SELECT && frame == FR_MAIN &&
    kind == flash_host_pkg::K_SUSPEND |-> gapCnt == '0)
    else $error("suspend sent too soon after resume");

  bank_refuse_a: assert property (
    wrCtrl && state == ST_IDLE && reqKind == flash_host_pkg::K_PROGRAM &&
    reqBankHit |=> refused && state == ST_IDLE)
    else $error("program into suspended bank not refused");

  enhance_exit_a: assert property (
    state == ST_SELECT && frame == FR_MAIN &&
    kind == flash_host_pkg::K_RESUME |-> !cfgEnhance)
    else $error("resume sent while enhance mode active");

  lock_cover: cover property (cmdDone && kind == flash_host_pkg::K_LOCK);
  suspend_cover: cover property (state == ST_LATENCY ##1 state == ST_IDLE);
  exit_cover: cover property (frameEnd && frame == FR_EXIT);
  refuse_cover: cover property (refuseNow && reqBankHit);

endmodule

// ===== tb/flash_dev_model.sv
module flash_dev_model (
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] din,
  input wire logic [3:0] oe,
  output logic [3:0] dout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh, tx, ops[$];
  logic write_enable_latch, busy, ers, eSus, pSus, locked, qpi, arm;
  int n, lastN, bad;
  initial begin
    {write_enable_latch, busy, ers, eSus, pSus, qpi, arm} = 7'h0;
    locked = 1'b1;
    n = 0;
    lastN = 0;
    bad = 0;
    sh = 8'h00;
    tx = 8'h00;
    dout = 4'h0;
  end
  always @(negedge csN) n = 0;
  always @(posedge sclk) if (!csN) begin
    if (n < 8 && oe !== (qpi ? 4'hF : 4'h1)) bad++;
    sh = qpi ? {sh[3:0], din} : {sh[6:0], din[0]};
    n = n + (qpi ? 4 : 1);
    if (n == 8) begin
      ops.push_back(sh);
      tx = sh == 8'h05 ? {6'h0, write_enable_latch, busy} : {4'h0, eSus, pSus, 2'h0};
    end
  end
  always @(negedge sclk) if (!csN && n >= 8) begin
    dout = {2'h0, tx[7], 1'b0};
    tx = {tx[6:0], 1'b0};
  end
  // A released line shows the inverse of its last value.
  always @(posedge csN) begin
    dout = ~dout;
    lastN = n;
    if (n >= 8) case (ops[$])
      8'h06: write_enable_latch = 1'b1;
      8'h7E, 8'h98: if (n == 8 && write_enable_latch) begin
        locked = ops[$] == 8'h7E;
        write_enable_latch = 1'b0;
      end else bad++;
      8'h20, 8'h02: if (write_enable_latch && !busy) begin
        busy = !eSus;
        ers = eSus || ops[$] == 8'h20;
        write_enable_latch = 1'b0;
      end else bad++;
      8'h75: if (busy) begin
        busy = 1'b0;
        write_enable_latch = 1'b0;
        eSus = ers;
        pSus = !ers;
      end
      8'h7A: if (eSus || pSus) begin
        busy = 1'b1;
        {eSus, pSus} = 2'h0;
      end
      8'h99: if (arm && !eSus) {write_enable_latch, busy, pSus} = 3'h0;
      default: ;
    endcase
    if (n >= 8) arm = ops[$] == 8'h66;
  end
endmodule

// ===== tb/test_flash_gang_suspend_host.sv
module test_flash_gang_suspend_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, rd, wr, wq, csN, sck;
  logic [2:0] adr;
  logic [31:0] wd, rdat, q;
  logic [3:0] dOut, dOe, dIn;
  int failures, check_count, cyc, k;
  flash_gang_suspend_host #(.RESUME_GAP(50), .SUSPEND_GAP(20),
    .SCLK_HALF(4)) dut_u (.clk(clk), .resetn(resetn), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wq), .flashCsN(csN),
    .flashSclk(sck), .flashDataOut(dOut), .flashDataOe(dOe),
    .flashDataIn(dIn));
  flash_dev_model m_u (.csN(csN), .sclk(sck), .din(dOut), .oe(dOe),
    .dout(dIn));
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a,
      input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] kind);
    bus(1'b1, flash_host_pkg::REG_CTRL, {28'h0, kind});
    do bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
    while (q[flash_host_pkg::STAT_BUSY] !== 1'b0);
  endtask
  task automatic s_lock;
    cmd(flash_host_pkg::K_LOCK);
    chk("write_enable_cmd", 32'h06, m_u.ops[m_u.ops.size()-2]);
    chk("lock", 32'h7E, m_u.ops[$]);
    chk("clocks", 32'h8, m_u.lastN);
    cmd(flash_host_pkg::K_UNLOCK);
    chk("unlock", 32'h98, m_u.ops[$]);
    chk("unlocked", 32'h0, 32'(m_u.locked));
  endtask
  task automatic s_quad;
    bus(1'b1, flash_host_pkg::REG_CONFIG, 32'h1);
    m_u.qpi = 1'b1;
    cmd(flash_host_pkg::K_WRITE_ENABLE_CMD);
    cmd(flash_host_pkg::K_RESET_ARM);
    cmd(flash_host_pkg::K_NOOP);
    cmd(flash_host_pkg::K_RESET);
    chk("qclocks", 32'h8, m_u.lastN);
    chk("noop", 32'h1, 32'(m_u.write_enable_latch));
    cmd(flash_host_pkg::K_RESET_ARM);
    cmd(flash_host_pkg::K_RESET);
    chk("reset", 32'h0, 32'(m_u.write_enable_latch));
    bus(1'b1, flash_host_pkg::REG_CONFIG, 32'h0);
    m_u.qpi = 1'b0;
  endtask
  task automatic s_suspend;
    bus(1'b1, flash_host_pkg::REG_ADDR, 32'h080000);
    cmd(flash_host_pkg::K_ERASE);
    k = cyc;
    cmd(flash_host_pkg::K_SUSPEND);
    chk("suspend", 32'h75, m_u.ops[$]);
    chk("latency", 32'h1, {31'h0, cyc - k >= 20 + 64});
    cmd(flash_host_pkg::K_RD_SECURITY);
    chk("esb", 32'h1, 32'(q[flash_host_pkg::STAT_ERASE_SUS]));
    k = m_u.ops.size();
    bus(1'b1, flash_host_pkg::REG_ADDR, 32'h0C0000);
    cmd(flash_host_pkg::K_PROGRAM);
    chk("refused", 32'h1, 32'(q[flash_host_pkg::STAT_REFUSED]));
    chk("frames", k, m_u.ops.size());
    bus(1'b1, flash_host_pkg::REG_ADDR, 32'h000000);
    cmd(flash_host_pkg::K_PROGRAM);
    chk("wren2", 32'h06, m_u.ops[m_u.ops.size()-2]);
    chk("program", 32'h02, m_u.ops[$]);
    bus(1'b1, flash_host_pkg::REG_CONFIG, 32'h2);
    cmd(flash_host_pkg::K_RESUME);
    chk("exit", 32'hFF, m_u.ops[m_u.ops.size()-2]);
    chk("resume", 32'h7A, m_u.ops[$]);
    bus(1'b0, flash_host_pkg::REG_CONFIG, 32'h0);
    chk("enhance", 32'h0, q);
    k = cyc;
    cmd(flash_host_pkg::K_SUSPEND);
    chk("gap", 32'h1, {31'h0, cyc - k >= 50 + 64});
    cmd(flash_host_pkg::K_RESUME);
    cmd(flash_host_pkg::K_RD_SECURITY);
    chk("esb", 32'h0, 32'(q[flash_host_pkg::STAT_ERASE_SUS]));
    bus(1'b0, 3'h7, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("model", 32'h0, m_u.bad);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    {resetn, rd, wr, adr, wd} = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    s_lock();
    s_quad();
    s_suspend();
    tally_and_finish();
  end
endmodule
